// [src/wdbus_params.svh]
// Purpose: named constants for the watchdog and transceiver control registers
// Assumes: 7-bit register addresses, 16-bit serial frames, MSB first
// Notes: included by the package, the frame shifter and the register block; not by the synchroniser
`ifndef WDBUS_PARAMS_SVH
`define WDBUS_PARAMS_SVH

// register addresses
`define ADDR_WATCHDOG_CONTROL 7'h03
`define ADDR_TRANSCEIVER_MODE 7'h04
`define ADDR_PEAK_THRESHOLD 7'h05

// power-on and soft reset values
`define RST_WATCHDOG_CONTROL 8'h14
`define RST_TRANSCEIVER_MODE 8'h20
`define RST_PEAK_THRESHOLD 8'h00

// implemented bits; reserved positions are zero here
`define MASK_WATCHDOG_CONTROL 8'hF7
`define MASK_TRANSCEIVER_MODE 8'hFB
`define MASK_PEAK_THRESHOLD 8'h20

// watchdog control fields
`define WD_CHECKSUM_BIT 7
`define WD_STOP_LOW_BIT 6
`define WD_TYPE_BIT 5
`define WD_BUS_WAKE_BIT 4
`define WD_RESERVED_BIT 3
`define WD_PERIOD_MSB 2
`define WD_PERIOD_LSB 0
`define WD_RESTART_PERIOD 3'h4

// transceiver mode fields
`define TM_FLASH_BIT 7
`define TM_SLOPE_BIT 6
`define TM_TIMEOUT_BIT 5
`define TM_LIN_MSB 4
`define TM_LIN_LSB 3
`define TM_RESERVED_BIT 2
`define TM_CAN_MSB 1
`define TM_CAN_LSB 0
`define FS_LIN_MODE 2'h1
`define FS_CAN_MODE 2'h1

// peak threshold field
`define PK_THRESHOLD_BIT 5
`define FS_PEAK_THRESHOLD 1'h0

// serial frame layout
`define FRAME_BITS 5'h10
`define FRAME_HEAD_LAST 5'h07
`define FRAME_CNT_MAX 5'h1F
`define FRAME_WRITE_BIT 15
`define FRAME_ADDR_MSB 14
`define FRAME_ADDR_LSB 8
`define MISO_HEAD 8'h00

`endif

// [src/wdbus_pkg.sv]
// Purpose: shared types for the control register block
// Assumes: constants come from wdbus_params.svh
// Notes: one-hot codes for the frame state machine
`include "wdbus_params.svh"
package wdbus_pkg;
	typedef enum logic [1:0] {
		SH_IDLE = 2'b01,
		SH_SHIFT = 2'b10
	} shift_state_t;

	typedef struct packed {
		shift_state_t st;
		logic [4:0] cnt;
		logic [15:0] rx;
		logic [7:0] tx;
		logic miso;
		logic sclk_prev;
		logic csn_prev;
		logic head_load;
		logic done;
	} shifter_state_t;

	typedef struct packed {
		logic [7:0] wd;
		logic [7:0] tm;
		logic [7:0] pk;
		logic serial_err;
		logic cks_err;
	} regs_state_t;
endpackage : wdbus_pkg

// [src/sync_2ff.sv]
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are slow levels relative to sys_clk
// Notes: the first stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module sync_2ff #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} sync_state_t;

	sync_state_t s_q;
	sync_state_t s_d;

	// shift one stage per clock
	always_comb begin
		s_d.meta = d;
		s_d.sync = s_q.meta;
	end

	// reset to the idle level of the pins
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_q <= {RESET_VAL, RESET_VAL};
		end else begin
			s_q <= s_d;
		end
	end

	assign q = s_q.sync;
endmodule : sync_2ff
`default_nettype wire

// [src/serial_frame.sv]
// Purpose: serial slave frame shifter, clock-phase 0, MSB first
// Assumes: sclk, mosi and select already synchronised to sys_clk
// Notes: sclk must stay below about sys_clk / 8 so the read byte loads in time
`timescale 1ns/10ps
`default_nettype none
`include "wdbus_params.svh"
module serial_frame
	import wdbus_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic sclk_s,
	input wire logic mosi_s,
	input wire logic csn_s,
	input wire logic [7:0] rd_data,
	output logic [6:0] head_addr,
	output logic frame_done,
	output logic frame_ok,
	output logic [15:0] frame_word,
	output logic miso,
	output logic miso_oe
);
	// read frames open with this byte before the addressed register
	localparam logic [7:0] head_byte = `MISO_HEAD;
	shifter_state_t s_q;
	shifter_state_t s_d;
	logic sclk_rise;
	logic sclk_fall;

	assign sclk_rise = sclk_s & ~s_q.sclk_prev;
	assign sclk_fall = ~sclk_s & s_q.sclk_prev;

	// frame sequencing: select low opens, select high closes
	always_comb begin
		s_d = s_q;
		s_d.sclk_prev = sclk_s;
		s_d.csn_prev = csn_s;
		s_d.head_load = 1'b0;
		s_d.done = 1'b0;
		case (s_q.st)
			SH_IDLE: begin
				if (s_q.csn_prev && !csn_s) begin
					s_d.st = SH_SHIFT;
					s_d.cnt = '0;
					s_d.rx = '0;
					s_d.miso = head_byte[7];
					s_d.tx = head_byte << 1;
				end
			end
			SH_SHIFT: begin
				if (csn_s) begin
					s_d.st = SH_IDLE;
					s_d.done = 1'b1;
				end else begin
					if (sclk_rise) begin
						s_d.rx = {s_q.rx[14:0], mosi_s};
						// saturate so overlong frames stay detectable
						if (s_q.cnt != `FRAME_CNT_MAX) begin
							s_d.cnt = s_q.cnt + 5'h01;
						end
						s_d.head_load = (s_q.cnt == `FRAME_HEAD_LAST);
					end
					if (s_q.head_load) begin
						s_d.tx = rd_data;
					end else if (sclk_fall) begin
						s_d.miso = s_q.tx[7];
						s_d.tx = {s_q.tx[6:0], 1'b0};
					end
				end
			end
			default: begin
				s_d.st = SH_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_q <= '{st: SH_IDLE, csn_prev: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign head_addr = s_q.rx[6:0];
	assign frame_done = s_q.done;
	assign frame_ok = (s_q.cnt == `FRAME_BITS);
	assign frame_word = s_q.rx;
	assign miso = s_q.miso;
	assign miso_oe = (s_q.st == SH_SHIFT);
endmodule : serial_frame
`default_nettype wire

// [src/watchdog_and_bus_control_regs.sv]
// Purpose: watchdog, transceiver mode and peak threshold control registers
// Assumes: mode and hardware update inputs come from logic on sys_clk
// Notes: frame = write bit, 7-bit address, data byte; writes land at select high
//
// Summary of operation
// - watchdog bit 6 low half of stop deactivation; one turns it off
// - watchdog bit 5 picks window supervision, zero picks time-out
// - watchdog bit 4 starts supervision after a bus wake from stop
// - reserved bits ignore writes and read as zero
// - transceiver bit 7 flash mode switches off transmit slope control
// - transceiver bit 6 selects low slope operation
// - transceiver bit 5 enables the transmit data time-out
// - transceiver bits 4:3 LIN mode, also loadable by hardware
// - transceiver bits 1:0 CAN mode, also loadable by hardware
// - slope, flash and time-out changes act when select returns high
// - fail-safe entry loads both transceivers wake capable, threshold zero
// - threshold bit 5 selects the higher active peak threshold
// - threshold bit writable only in init or normal mode
// - in stop mode threshold writes drop silently, no serial error
// - restart clears stop deactivation bit, period code becomes four
// - high stop deactivation bit joins the low one for stop mode
`timescale 1ns/10ps
`default_nettype none
`include "wdbus_params.svh"
module watchdog_and_bus_control_regs
	import wdbus_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic chip_select_low_active,
	output logic miso,
	output logic miso_oe,
	input wire logic mode_init,
	input wire logic mode_normal,
	input wire logic mode_stop,
	input wire logic restart_entry,
	input wire logic failsafe_entry,
	input wire logic soft_reset,
	input wire logic stop_disable_high_bit,
	input wire logic hw_period_we,
	input wire logic [2:0] hw_period_code,
	input wire logic hw_lin_we,
	input wire logic [1:0] hw_lin_mode,
	input wire logic hw_can_we,
	input wire logic [1:0] hw_can_mode,
	output logic stop_disable_low_bit,
	output logic supervision_type_select,
	output logic start_after_bus_wake,
	output logic [2:0] supervision_period_code,
	output logic flash_mode_select,
	output logic low_slope_select,
	output logic transmit_timeout_enable,
	output logic [1:0] first_transceiver_mode,
	output logic [1:0] can_transceiver_mode,
	output logic active_peak_threshold_select,
	output logic watchdog_stop_inactive,
	output logic serial_error,
	output logic checksum_error
);
	regs_state_t r_q;
	regs_state_t r_d;
	logic [2:0] pins_s;
	logic [6:0] head_addr;
	logic [7:0] rd_data;
	logic frame_done;
	logic frame_ok;
	logic [15:0] frame_word;
	logic [6:0] w_addr;
	logic [7:0] w_data;
	logic wr_go;
	logic wr_wd;
	logic wr_tm;
	logic wr_pk;
	logic parity_bad;
	logic peak_open;
	logic quiet;

	// pins cross into sys_clk; select idles high
	sync_2ff #(.W(3), .RESET_VAL(3'h4)) u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.d({chip_select_low_active, sclk, mosi}),
		.q(pins_s)
	);

	serial_frame u_frame (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.sclk_s(pins_s[1]),
		.mosi_s(pins_s[0]),
		.csn_s(pins_s[2]),
		.rd_data(rd_data),
		.head_addr(head_addr),
		.frame_done(frame_done),
		.frame_ok(frame_ok),
		.frame_word(frame_word),
		.miso(miso),
		.miso_oe(miso_oe)
	);

	// read mux; unmapped addresses read zero
	always_comb begin
		case (head_addr)
			`ADDR_WATCHDOG_CONTROL: rd_data = r_q.wd & `MASK_WATCHDOG_CONTROL;
			`ADDR_TRANSCEIVER_MODE: rd_data = r_q.tm & `MASK_TRANSCEIVER_MODE;
			`ADDR_PEAK_THRESHOLD: rd_data = r_q.pk & `MASK_PEAK_THRESHOLD;
			default: rd_data = 8'h00;
		endcase
	end

	// write decode, valid only for complete frames
	assign w_addr = frame_word[`FRAME_ADDR_MSB:`FRAME_ADDR_LSB];
	assign w_data = frame_word[7:0];
	assign wr_go = frame_done & frame_ok & frame_word[`FRAME_WRITE_BIT];
	assign parity_bad = ^w_data;
	assign wr_wd = wr_go & (w_addr == `ADDR_WATCHDOG_CONTROL);
	assign wr_tm = wr_go & (w_addr == `ADDR_TRANSCEIVER_MODE);
	assign wr_pk = wr_go & (w_addr == `ADDR_PEAK_THRESHOLD);
	assign peak_open = mode_init | mode_normal;
	assign quiet = ~soft_reset & ~failsafe_entry & ~restart_entry;

	// register update; later statements win: spi, hardware, restart, fail-safe, soft
	always_comb begin
		r_d = r_q;
		r_d.serial_err = 1'b0;
		r_d.cks_err = 1'b0;
		// a bad checksum refuses the whole byte, so a corrupted period never lands
		if (wr_wd && parity_bad) begin
			r_d.cks_err = 1'b1;
		end else if (wr_wd) begin
			r_d.wd = w_data & `MASK_WATCHDOG_CONTROL;
		end
		if (wr_tm) begin
			r_d.tm = w_data & `MASK_TRANSCEIVER_MODE;
		end
		// stop mode drops the write with no error flag
		if (wr_pk && peak_open) begin
			r_d.pk = w_data & `MASK_PEAK_THRESHOLD;
		end
		r_d.serial_err = (frame_done & ~frame_ok) | (wr_wd & parity_bad);
		// hardware updates beat a simultaneous host write
		if (hw_period_we) begin
			r_d.wd[`WD_PERIOD_MSB:`WD_PERIOD_LSB] = hw_period_code;
		end
		if (hw_lin_we) begin
			r_d.tm[`TM_LIN_MSB:`TM_LIN_LSB] = hw_lin_mode;
		end
		if (hw_can_we) begin
			r_d.tm[`TM_CAN_MSB:`TM_CAN_LSB] = hw_can_mode;
		end
		if (restart_entry) begin
			r_d.wd[`WD_STOP_LOW_BIT] = 1'b0;
			r_d.wd[`WD_RESERVED_BIT] = 1'b0;
			r_d.wd[`WD_PERIOD_MSB:`WD_PERIOD_LSB] = `WD_RESTART_PERIOD;
		end
		// bus wake sources must survive so the device can be woken again
		if (failsafe_entry) begin
			r_d.tm[`TM_LIN_MSB:`TM_LIN_LSB] = `FS_LIN_MODE;
			r_d.tm[`TM_RESERVED_BIT] = 1'b0;
			r_d.tm[`TM_CAN_MSB:`TM_CAN_LSB] = `FS_CAN_MODE;
			r_d.pk[`PK_THRESHOLD_BIT] = `FS_PEAK_THRESHOLD;
		end
		if (soft_reset) begin
			r_d.wd = `RST_WATCHDOG_CONTROL;
			r_d.tm = `RST_TRANSCEIVER_MODE;
			r_d.pk = `RST_PEAK_THRESHOLD;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r_q.wd <= `RST_WATCHDOG_CONTROL;
			r_q.tm <= `RST_TRANSCEIVER_MODE;
			r_q.pk <= `RST_PEAK_THRESHOLD;
			r_q.serial_err <= 1'b0;
			r_q.cks_err <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	// control outputs straight from the registers
	assign stop_disable_low_bit = r_q.wd[`WD_STOP_LOW_BIT];
	assign supervision_type_select = r_q.wd[`WD_TYPE_BIT];
	assign start_after_bus_wake = r_q.wd[`WD_BUS_WAKE_BIT];
	assign supervision_period_code = r_q.wd[`WD_PERIOD_MSB:`WD_PERIOD_LSB];
	assign flash_mode_select = r_q.tm[`TM_FLASH_BIT];
	assign low_slope_select = r_q.tm[`TM_SLOPE_BIT];
	assign transmit_timeout_enable = r_q.tm[`TM_TIMEOUT_BIT];
	assign first_transceiver_mode = r_q.tm[`TM_LIN_MSB:`TM_LIN_LSB];
	assign can_transceiver_mode = r_q.tm[`TM_CAN_MSB:`TM_CAN_LSB];
	assign active_peak_threshold_select = r_q.pk[`PK_THRESHOLD_BIT];
	assign serial_error = r_q.serial_err;
	assign checksum_error = r_q.cks_err;

	// both halves must be set before supervision stops in stop mode
	assign watchdog_stop_inactive = mode_stop & r_q.wd[`WD_STOP_LOW_BIT] & stop_disable_high_bit;

	// reserved bits never show on reads
	property p_reserved_zero;
		@(posedge sys_clk) disable iff (sys_rst)
		r_q.wd[`WD_RESERVED_BIT] == 1'b0 && r_q.tm[`TM_RESERVED_BIT] == 1'b0
			&& (r_q.pk & ~`MASK_PEAK_THRESHOLD) == 8'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved register bit became nonzero");

	// odd-parity watchdog byte is flagged and leaves the register alone
	property p_checksum_refuse;
		@(posedge sys_clk) disable iff (sys_rst)
		wr_wd && parity_bad && quiet && !hw_period_we |=> checksum_error && serial_error
			&& $stable(r_q.wd);
	endproperty
	a_checksum_refuse: assert property (p_checksum_refuse)
		else $error("odd parity watchdog write not refused");

	// good watchdog write sets type and bus wake start
	property p_wd_write;
		@(posedge sys_clk) disable iff (sys_rst)
		wr_wd && !parity_bad && quiet |=> supervision_type_select == $past(w_data[`WD_TYPE_BIT])
			&& start_after_bus_wake == $past(w_data[`WD_BUS_WAKE_BIT]) && !checksum_error;
	endproperty
	a_wd_write: assert property (p_wd_write)
		else $error("watchdog write did not land");

	// slope and time-out act right after the frame closes
	property p_slope_at_close;
		@(posedge sys_clk) disable iff (sys_rst)
		wr_tm && quiet |=> low_slope_select == $past(w_data[`TM_SLOPE_BIT])
			&& transmit_timeout_enable == $past(w_data[`TM_TIMEOUT_BIT])
			&& flash_mode_select == $past(w_data[`TM_FLASH_BIT]);
	endproperty
	a_slope_at_close: assert property (p_slope_at_close)
		else $error("slope settings late after select high");

	// restart values in the watchdog register
	property p_restart;
		@(posedge sys_clk) disable iff (sys_rst)
		restart_entry && !soft_reset && !(wr_wd && !parity_bad)
			|=> supervision_period_code == `WD_RESTART_PERIOD && !stop_disable_low_bit
			&& $stable(supervision_type_select) && $stable(start_after_bus_wake);
	endproperty
	a_restart: assert property (p_restart)
		else $error("restart values wrong in watchdog register");

	// fail-safe leaves both transceivers wake capable
	property p_failsafe;
		@(posedge sys_clk) disable iff (sys_rst)
		failsafe_entry && !soft_reset && !wr_tm |=> first_transceiver_mode == `FS_LIN_MODE
			&& can_transceiver_mode == `FS_CAN_MODE && !active_peak_threshold_select
			&& $stable(flash_mode_select) && $stable(low_slope_select)
			##1 (first_transceiver_mode != 2'h0 || $past(hw_lin_we) || $past(soft_reset)
			|| $past(wr_tm));
	endproperty
	a_failsafe: assert property (p_failsafe)
		else $error("fail-safe load of transceiver modes wrong");

	// stop mode: threshold write dropped with no error
	property p_peak_stop;
		@(posedge sys_clk) disable iff (sys_rst)
		wr_pk && mode_stop && !mode_init && !mode_normal && quiet
			|=> $stable(active_peak_threshold_select) && !serial_error;
	endproperty
	a_peak_stop: assert property (p_peak_stop)
		else $error("threshold changed or error raised in stop mode");

	// init or normal: threshold write accepted
	property p_peak_open;
		@(posedge sys_clk) disable iff (sys_rst)
		wr_pk && peak_open && quiet
			|=> active_peak_threshold_select == $past(w_data[`PK_THRESHOLD_BIT]);
	endproperty
	a_peak_open: assert property (p_peak_open)
		else $error("threshold write lost in init or normal mode");

	// hardware mode update wins over a host write
	property p_hw_lin;
		@(posedge sys_clk) disable iff (sys_rst)
		hw_lin_we && !soft_reset && !failsafe_entry |=> first_transceiver_mode == $past(hw_lin_mode);
	endproperty
	a_hw_lin: assert property (p_hw_lin)
		else $error("hardware LIN mode update lost");

	// hardware CAN mode update wins over a host write
	property p_hw_can;
		@(posedge sys_clk) disable iff (sys_rst)
		hw_can_we && !soft_reset && !failsafe_entry |=> can_transceiver_mode == $past(hw_can_mode);
	endproperty
	a_hw_can: assert property (p_hw_can)
		else $error("hardware CAN mode update lost");

	// hardware period load lands unless restart or soft reset overrides it
	property p_hw_period;
		@(posedge sys_clk) disable iff (sys_rst)
		hw_period_we && !soft_reset && !restart_entry
			|=> supervision_period_code == $past(hw_period_code);
	endproperty
	a_hw_period: assert property (p_hw_period)
		else $error("hardware period load lost");

	// supervision never stopped outside stop mode
	property p_stop_gate;
		@(posedge sys_clk) disable iff (sys_rst)
		!mode_stop || !stop_disable_high_bit |-> !watchdog_stop_inactive;
	endproperty
	a_stop_gate: assert property (p_stop_gate)
		else $error("watchdog deactivated without both stop bits");
endmodule : watchdog_and_bus_control_regs
`default_nettype wire

// [sim/host_model.sv]
// Purpose: host serial master model that drives register frames
// Assumes: sclk idles low, mosi changes while sclk is low, MSB first
// Notes: sclk high for six and low for twelve system clocks keeps inside the slave's limit
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input wire logic sys_clk,
	input wire logic miso,
	output logic sclk,
	output logic mosi,
	output logic chip_select_low_active
);
	// idle levels; sclk stands still between frames
	initial begin
		sclk = 1'b0;
		mosi = 1'b0;
		chip_select_low_active = 1'b1;
	end

	// one frame; nb below 16 gives a truncated frame
	task automatic xfer(input logic [15:0] w, input int nb, output logic [7:0] rd);
		logic [15:0] sh;
		sh = '0;
		@(negedge sys_clk);
		chip_select_low_active = 1'b0;
		for (int i = 0; i < nb; i++) begin
			repeat (6) @(negedge sys_clk);
			mosi = w[15-i];
			repeat (6) @(negedge sys_clk);
			sclk = 1'b1;
			sh = {sh[14:0], miso};
			repeat (6) @(negedge sys_clk);
			sclk = 1'b0;
		end
		repeat (6) @(negedge sys_clk);
		chip_select_low_active = 1'b1;
		// released line: flip it so no stale bit looks valid
		mosi = ~mosi;
		repeat (10) @(negedge sys_clk);
		rd = sh[7:0];
	endtask : xfer
endmodule : host_model
`default_nettype wire

// [sim/tb.sv]
// Purpose: self-checking bench for the control register block
// Assumes: host_model is the serial master, inputs change on falling edges
// Notes: a byte model of the three registers is compared after every event
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("wrong value %s expected %h seen %h", nm, (e), (g)); end end
module tb;
	logic sys_clk, sys_rst, sclk, mosi, cs_n, miso;
	logic mode_init, mode_normal, mode_stop, restart_entry, failsafe_entry, soft_reset;
	logic stop_hi, hp_we, hl_we, hc_we;
	logic [2:0] hp_code, o_per;
	logic [1:0] hl_mode, hc_mode, lin_m, can_m;
	logic o_lo, o_type, o_wake, o_flash, o_slope, o_to, o_peak, o_inact, o_ser, o_cks, o_oe;
	logic [7:0] mwd, mtm, mpk, d;
	logic [6:0] a;
	int mismatches, n_checks, n_ser, n_cks, e_ser, e_cks;

	watchdog_and_bus_control_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .sclk(sclk),
		.mosi(mosi), .chip_select_low_active(cs_n), .miso(miso), .miso_oe(o_oe),
		.mode_init(mode_init), .mode_normal(mode_normal), .mode_stop(mode_stop),
		.restart_entry(restart_entry), .failsafe_entry(failsafe_entry),
		.soft_reset(soft_reset), .stop_disable_high_bit(stop_hi), .hw_period_we(hp_we),
		.hw_period_code(hp_code), .hw_lin_we(hl_we), .hw_lin_mode(hl_mode),
		.hw_can_we(hc_we), .hw_can_mode(hc_mode), .stop_disable_low_bit(o_lo),
		.supervision_type_select(o_type), .start_after_bus_wake(o_wake),
		.supervision_period_code(o_per), .flash_mode_select(o_flash),
		.low_slope_select(o_slope), .transmit_timeout_enable(o_to),
		.first_transceiver_mode(lin_m), .can_transceiver_mode(can_m),
		.active_peak_threshold_select(o_peak), .watchdog_stop_inactive(o_inact),
		.serial_error(o_ser), .checksum_error(o_cks));

	host_model host (.sys_clk(sys_clk), .miso(miso), .sclk(sclk), .mosi(mosi),
		.chip_select_low_active(cs_n));

	// free-running system clock
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// error pulses are one cycle wide, so count every one
	always @(posedge sys_clk) begin
		// an unknown level counts as a pulse so it cannot slip past
		if (!sys_rst && o_ser !== 1'b0) n_ser++;
		if (!sys_rst && o_cks !== 1'b0) n_cks++;
	end

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	// outputs, error counts and read-back of the three registers and one unmapped address
	task automatic check_all;
		logic [7:0] r;
		`CHK("wd", mwd[6:0], {o_lo, o_type, o_wake, 1'b0, o_per})
		`CHK("tm", mtm, {o_flash, o_slope, o_to, lin_m, 1'b0, can_m})
		`CHK("pk", mpk[5], o_peak)
		`CHK("inact", mode_stop & mwd[6] & stop_hi, o_inact)
		`CHK("ser", e_ser, n_ser)
		`CHK("cks", e_cks, n_cks)
		`CHK("oe", 1'b0, o_oe)
		for (int i = 3; i < 7; i++) begin
			host.xfer({1'b0, i[6:0], 8'h00}, 16, r);
			`CHK("read", (i == 3) ? mwd : (i == 4) ? mtm : (i == 5) ? mpk : 8'h00, r)
		end
	endtask : check_all

	// write frame; the model applies what the device should keep
	task automatic wr(input logic [6:0] wa, input logic [7:0] wd, input int nb);
		logic [7:0] r;
		host.xfer({1'b1, wa, wd}, nb, r);
		if (nb != 16) begin
			e_ser++;
		end else if (wa == 7'h03) begin
			if (^wd) begin
				e_ser++;
				e_cks++;
			end else mwd = wd & 8'hF7;
		end else if (wa == 7'h04) begin
			mtm = wd & 8'hFB;
		end else if (wa == 7'h05 && (mode_init || mode_normal)) begin
			mpk = wd & 8'h20;
		end
	endtask : wr

	// one-cycle hardware or mode event, then full comparison
	task automatic ev(input int k);
		@(negedge sys_clk);
		hp_code = 3'($urandom_range(0, 7));
		hl_mode = 2'($urandom_range(0, 3));
		hc_mode = 2'($urandom_range(0, 3));
		case (k)
			0: begin hp_we = 1'b1; mwd[2:0] = hp_code; end
			1: begin hl_we = 1'b1; mtm[4:3] = hl_mode; end
			2: begin hc_we = 1'b1; mtm[1:0] = hc_mode; end
			3: begin restart_entry = 1'b1; mwd = (mwd & 8'hB0) | 8'h04; end
			4: begin failsafe_entry = 1'b1; mtm = (mtm & 8'hE0) | 8'h09; mpk = '0; end
			default: begin soft_reset = 1'b1; mwd = 8'h14; mtm = 8'h20; mpk = '0; end
		endcase
		@(negedge sys_clk);
		{hp_we, hl_we, hc_we, restart_entry, failsafe_entry, soft_reset} = '0;
		repeat (3) @(negedge sys_clk);
		check_all();
	endtask : ev

	// watchdog sized above the roughly 82k cycles the tests need
	initial begin
		repeat (95000) @(posedge sys_clk);
		mismatches++;
		conclude();
	end

	initial begin
		sys_rst = 1'b1;
		{mode_init, mode_normal, mode_stop, stop_hi} = 4'b0100;
		{hp_we, hl_we, hc_we, restart_entry, failsafe_entry, soft_reset} = '0;
		{hp_code, hl_mode, hc_mode} = '0;
		void'($urandom(21));
		repeat (8) @(negedge sys_clk);
		sys_rst = 1'b0;
		mwd = 8'h14;
		mtm = 8'h20;
		mpk = 8'h00;
		repeat (4) @(negedge sys_clk);
		check_all();
		$display("test reset done");
		// random mode, address and data, including unmapped and bad parity
		for (int i = 0; i < 40; i++) begin
			{mode_init, mode_normal, mode_stop} = 3'b001 << $urandom_range(0, 2);
			stop_hi = 1'($urandom_range(0, 1));
			a = 7'($urandom_range(3, 6));
			d = 8'($urandom);
			d[7] = ^d[6:0];
			if (a == 7'h03 && $urandom_range(0, 3) == 0) d[7] = ~d[7];
			wr(a, d, 16);
			check_all();
		end
		$display("test random writes done");
		wr(7'h04, 8'hFF, 15);
		check_all();
		$display("test short frame done");
		// directed refusals: odd parity watchdog byte, threshold flip in stop mode
		{mode_init, mode_normal, mode_stop} = 3'b001;
		wr(7'h03, 8'h01, 16);
		check_all();
		wr(7'h05, ~mpk, 16);
		check_all();
		// output enable must stand while a frame is open
		fork
			host.xfer({1'b0, 7'h03, 8'h00}, 16, d);
			begin
				repeat (100) @(negedge sys_clk);
				`CHK("oe", 1'b1, o_oe)
			end
		join
		`CHK("read", mwd, d)
		$display("test refusals done");
		for (int k = 0; k < 12; k++) ev(k % 6);
		$display("test events done");
		conclude();
	end
endmodule : tb
`default_nettype wire
